// [hw/dlsc_config.sv]
// dead-time, loop-response and rail-order configuration for one rail
//
// What this block does
// - H-to-L bit 15: 0 adaptive, 1 frozen
// - bits 14:8 floor adaptive H-to-L gap
// - L-to-H bit 7: 0 adaptive, 1 frozen
// - bits 6:0 floor adaptive L-to-H gap
// - dead-time setup resets to 0808h
// - loop setup: enable, residual, gain fields
// - loop setup resets to 015A0100h
// - gain derived from voltages, residual set to baseline
// - prequel: turn on after its power-good
// - sequel: delayed turn-off after its power-down
// - bit 15 prequel enable, 12:8 id
// - bit 7 sequel enable, 4:0 id
// - disabled links wait for no event
// - written register overrides strap configuration
// - rail-order register resets to zero
// - freezing keeps last adaptive gap
`timescale 1ns/10ps
`include "dlsc_params.svh"
module dlsc_config #(
  parameter int VOLT_W = 12  // width of measured voltage codes
) (
  input  wire logic              sys_clk_in,         // 20 MHz system clock
  input  wire logic              rst_in,             // synchronous reset, high
  // management-bus command port
  input  wire logic              cmd_valid_in,       // command strobe
  input  wire logic              cmd_write_in,       // 1 write, 0 read
  input  wire logic [7:0]        cmd_code_in,        // command code
  input  wire logic [31:0]       cmd_wdata_in,       // write data
  output logic                   cmd_ack_out,        // answer strobe
  output logic                   cmd_err_out,        // unknown code
  output logic      [31:0]       cmd_rdata_out,      // read data
  // dead-time optimiser
  input  wire logic [6:0]        hl_adapt_in,        // H-to-L proposal
  input  wire logic              hl_adapt_valid_in,  // H-to-L strobe
  input  wire logic [6:0]        lh_adapt_in,        // L-to-H proposal
  input  wire logic              lh_adapt_valid_in,  // L-to-H strobe
  output logic      [6:0]        hl_gap_out,         // H-to-L gap in use
  output logic      [6:0]        lh_gap_out,         // L-to-H gap in use
  output logic                   hl_frozen_out,      // H-to-L frozen
  output logic                   lh_frozen_out,      // L-to-H frozen
  // loop-response control
  input  wire logic [VOLT_W-1:0] vin_in,             // measured input voltage
  input  wire logic [VOLT_W-1:0] vout_in,            // measured output voltage
  input  wire logic              derive_in,          // load derived defaults
  output logic                   loop_enable_out,    // control enabled
  output logic      [7:0]        loop_residual_out,  // residual in use
  output logic      [15:0]       loop_gain_out,      // gain in use
  // rail sequencing
  input  wire logic [15:0]       strap_order_in,     // strap-derived order pins
  input  wire logic              on_req_in,          // selected on/off condition
  input  wire logic              evt_valid_in,       // inter_chip_bus event strobe
  input  wire logic              evt_kind_in,        // 0 power-good, 1 power-down
  input  wire logic [4:0]        evt_id_in,          // sender identifier
  input  wire logic [15:0]       off_delay_in,       // turn-off delay, cycles
  output logic                   rail_on_out,        // output stage enabled
  output logic      [1:0]        rail_state_out      // sequencing state
);

  dlsc_pkg::dlsc_gap_cfg_t   switch_gap_setup_r;    // dead-time setup
  dlsc_pkg::dlsc_loop_cfg_t  loop_response_setup_r; // loop-response setup
  dlsc_pkg::dlsc_order_cfg_t rail_order_links_r;    // rail-order links
  logic                      order_written_r;       // host has written order

  logic [15:0] strap_meta_r;   // first synchroniser stage
  logic [15:0] strap_sync_r;   // second synchroniser stage
  logic [15:0] strap_cap_r;    // strap captured once after release
  logic [1:0]  strap_wait_r;   // cycles since reset release
  logic        strap_done_r;   // capture has happened

  logic        ack_r;          // registered answer strobe
  logic        err_r;          // registered unknown-code flag
  logic [31:0] rdata_r;        // registered read data

  dlsc_pkg::dlsc_order_cfg_t  order_eff;   // order in force
  dlsc_pkg::dlsc_rail_state_t state_r;     // rail state
  dlsc_pkg::dlsc_rail_state_t state_nxt;   // next rail state
  logic        pg_seen_r;      // predecessor power-good latched
  logic        pd_seen_r;      // successor power-down latched
  logic        pg_hit;         // matching power-good this cycle
  logic        pd_hit;         // matching power-down this cycle
  logic [15:0] delay_cnt_r;    // turn-off delay countdown
  logic        on_allowed;     // turn-on condition met
  logic        off_wanted;     // turn-off condition met

  // write strobes decoded per register, and the known-code flag
  logic        wr_gap;         // write to dead-time setup
  logic        wr_loop;        // write to loop setup
  logic        wr_order;       // write to rail-order links
  logic        code_known;     // code maps to a register

  // derived loop values
  dlsc_pkg::dlsc_loop_cfg_t derived;  // gain from voltages, residual at its baseline

  // one decode used by both write strobes and read mux
  function automatic logic dlsc_hit(input logic [7:0] code, input logic [7:0] want);
    dlsc_hit = (code == want);
  endfunction : dlsc_hit

  // default loop settings from the voltage difference; a larger vin minus
  // vout gets more gain. kept to a shift-and-add so no divider is needed
  function automatic dlsc_pkg::dlsc_loop_cfg_t dlsc_derive(
    input logic [VOLT_W-1:0] vin,
    input logic [VOLT_W-1:0] vout,
    input logic              en
  );
    logic [15:0] diff;
    diff = (vin > vout) ? 16'(vin - vout) : 16'h0000;
    dlsc_derive.unused = 7'h00;
    dlsc_derive.en     = en;
    dlsc_derive.res    = `DLSC_DERIVE_RES;
    dlsc_derive.gain   = `DLSC_DERIVE_GAIN + (diff >> 2);
  endfunction : dlsc_derive

  // events from another chip match only when the link is enabled
  function automatic logic dlsc_evt_match(
    input logic       valid,
    input logic       kind,
    input logic       want_kind,
    input logic [4:0] id,
    input logic       link_en,
    input logic [4:0] link_id
  );
    dlsc_evt_match = valid && (kind == want_kind) && link_en && (id == link_id);
  endfunction : dlsc_evt_match

  // strobes are combinational from the same-clock command port
  always_comb begin
    wr_gap     = cmd_valid_in && cmd_write_in && dlsc_hit(cmd_code_in, `DLSC_CMD_GAP);
    wr_loop    = cmd_valid_in && cmd_write_in && dlsc_hit(cmd_code_in, `DLSC_CMD_LOOP);
    wr_order   = cmd_valid_in && cmd_write_in && dlsc_hit(cmd_code_in, `DLSC_CMD_ORDER);
    code_known = dlsc_hit(cmd_code_in, `DLSC_CMD_GAP) ||
                 dlsc_hit(cmd_code_in, `DLSC_CMD_LOOP) ||
                 dlsc_hit(cmd_code_in, `DLSC_CMD_ORDER);
  end

  // all sixteen bits are defined, so the whole word is kept
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      switch_gap_setup_r <= `DLSC_GAP_RESET;
    end else if (wr_gap) begin
      switch_gap_setup_r <= cmd_wdata_in[15:0] & `DLSC_GAP_MASK;
    end
  end

  // a host write beats a derive request in the same cycle,
  // since the host asked for a specific value
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      loop_response_setup_r <= `DLSC_LOOP_RESET;
    end else if (wr_loop) begin
      loop_response_setup_r <= cmd_wdata_in & `DLSC_LOOP_MASK;
    end else if (derive_in) begin
      loop_response_setup_r <= derived;
    end
  end

  // derived values keep the present enable bit
  always_comb begin
    derived = dlsc_derive(vin_in, vout_in, loop_response_setup_r.en);
  end

  // once written the register stays in force until reset
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rail_order_links_r <= `DLSC_ORDER_RESET;
      order_written_r    <= 1'b0;
    end else if (wr_order) begin
      rail_order_links_r <= cmd_wdata_in[15:0] & `DLSC_ORDER_MASK;
      order_written_r    <= 1'b1;
    end
  end

  // strap pins are asynchronous; two stages before anything reads them
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      strap_meta_r <= 16'h0000;
      strap_sync_r <= 16'h0000;
    end else begin
      strap_meta_r <= strap_order_in;
      strap_sync_r <= strap_meta_r;
    end
  end

  // capture once, after the synchroniser has filled with pin values
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      strap_wait_r <= 2'h0;
      strap_done_r <= 1'b0;
      strap_cap_r  <= 16'h0000;
    end else if (!strap_done_r) begin
      if (strap_wait_r == `DLSC_STRAP_WAIT) begin
        strap_cap_r  <= strap_sync_r & `DLSC_ORDER_MASK;
        strap_done_r <= 1'b1;
      end else begin
        strap_wait_r <= strap_wait_r + 2'h1;
      end
    end
  end

  // the written register overrides the strap; before capture no link is used
  always_comb begin
    if (order_written_r) begin
      order_effective_sel: order_eff = rail_order_links_r;
    end else if (strap_done_r) begin
      order_eff = strap_cap_r;
    end else begin
      order_eff = `DLSC_ORDER_RESET;
    end
  end

  // every request is answered one cycle later; unknown codes flag an error
  // and read as zero, writes to them change nothing
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ack_r   <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= cmd_valid_in;
      err_r <= cmd_valid_in && !code_known;
      if (cmd_valid_in && !cmd_write_in) begin
        if (dlsc_hit(cmd_code_in, `DLSC_CMD_GAP)) begin
          rdata_r <= {16'h0000, switch_gap_setup_r};
        end else if (dlsc_hit(cmd_code_in, `DLSC_CMD_LOOP)) begin
          rdata_r <= loop_response_setup_r & `DLSC_LOOP_MASK;
        end else if (dlsc_hit(cmd_code_in, `DLSC_CMD_ORDER)) begin
          rdata_r <= {16'h0000, rail_order_links_r & `DLSC_ORDER_MASK};
        end else begin
          rdata_r <= 32'h00000000;
        end
      end
    end
  end

  assign cmd_ack_out   = ack_r;
  assign cmd_err_out   = err_r;
  assign cmd_rdata_out = rdata_r;

  // high-to-low transition
  dlsc_gap_track #(
    .RESET_GAP (7'(`DLSC_GAP_RESET >> `DLSC_GAP_HL_MIN_LSB))  // start at the reset floor
  ) u_gap_hl (
    .sys_clk_in     (sys_clk_in),
    .rst_in         (rst_in),
    .freeze_in      (switch_gap_setup_r.hl_frz),
    .floor_in       (switch_gap_setup_r.hl_min),
    .adapt_in       (hl_adapt_in),
    .adapt_valid_in (hl_adapt_valid_in),
    .gap_out        (hl_gap_out)
  );

  // low-to-high transition
  dlsc_gap_track #(
    .RESET_GAP (7'(`DLSC_GAP_RESET >> `DLSC_GAP_LH_MIN_LSB))  // start at the reset floor
  ) u_gap_lh (
    .sys_clk_in     (sys_clk_in),
    .rst_in         (rst_in),
    .freeze_in      (switch_gap_setup_r.lh_frz),
    .floor_in       (switch_gap_setup_r.lh_min),
    .adapt_in       (lh_adapt_in),
    .adapt_valid_in (lh_adapt_valid_in),
    .gap_out        (lh_gap_out)
  );

  assign hl_frozen_out = switch_gap_setup_r.hl_frz;
  assign lh_frozen_out = switch_gap_setup_r.lh_frz;

  // loop-response fields leave straight from the setup register
  assign loop_enable_out   = loop_response_setup_r.en;
  assign loop_residual_out = loop_response_setup_r.res;
  assign loop_gain_out     = loop_response_setup_r.gain;

  // events come from the bus receiver on this same clock
  always_comb begin
    pg_hit = dlsc_evt_match(evt_valid_in, evt_kind_in, 1'b0, evt_id_in,
                            order_eff.pre_en, order_eff.pre_id);
    pd_hit = dlsc_evt_match(evt_valid_in, evt_kind_in, 1'b1, evt_id_in,
                            order_eff.seq_en, order_eff.seq_id);
  end

  // power-good latch; cleared while the rail is off and not requested,
  // but a matching event in that same cycle still sets it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pg_seen_r <= 1'b0;
    end else if (pg_hit) begin
      pg_seen_r <= 1'b1;
    end else if (state_r == dlsc_pkg::DLSC_RAIL_OFF && !on_req_in) begin
      pg_seen_r <= 1'b0;
    end
  end

  // power-down latch; cleared when the rail reaches off, set wins
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pd_seen_r <= 1'b0;
    end else if (pd_hit) begin
      pd_seen_r <= 1'b1;
    end else if (state_r == dlsc_pkg::DLSC_RAIL_OFF) begin
      pd_seen_r <= 1'b0;
    end
  end

  // with a link disabled its event term is forced true or false
  always_comb begin
    on_allowed = on_req_in && (!order_eff.pre_en || pg_seen_r || pg_hit);
    off_wanted = !on_req_in || (order_eff.seq_en && (pd_seen_r || pd_hit));
  end

  // next-state logic; code 11 is unused and recovers to off
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dlsc_pkg::DLSC_RAIL_OFF: begin
        if (on_allowed) begin
          state_nxt = dlsc_pkg::DLSC_RAIL_ON;
        end
      end
      dlsc_pkg::DLSC_RAIL_ON: begin
        if (off_wanted) begin
          state_nxt = dlsc_pkg::DLSC_RAIL_DELAY;
        end
      end
      dlsc_pkg::DLSC_RAIL_DELAY: begin
        if (delay_cnt_r == 16'h0000) begin
          state_nxt = dlsc_pkg::DLSC_RAIL_OFF;
        end
      end
      default: begin
        state_nxt = dlsc_pkg::DLSC_RAIL_OFF;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_r <= dlsc_pkg::DLSC_RAIL_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // turn-off delay: loaded on entry to the delay state, counts to zero;
  // the output stays on for off_delay_in + 1 cycles after the cause
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      delay_cnt_r <= 16'h0000;
    end else if (state_r == dlsc_pkg::DLSC_RAIL_ON && off_wanted) begin
      delay_cnt_r <= off_delay_in;
    end else if (state_r == dlsc_pkg::DLSC_RAIL_DELAY && delay_cnt_r != 16'h0000) begin
      delay_cnt_r <= delay_cnt_r - 16'h0001;
    end
  end

  // the stage stays on through the delay state
  assign rail_on_out    = (state_r != dlsc_pkg::DLSC_RAIL_OFF);
  assign rail_state_out = state_r;

endmodule : dlsc_config

// [hw/dlsc_gap_track.sv]
// one switching transition's dead-time tracker: floor clamp and freeze
`timescale 1ns/10ps
module dlsc_gap_track #(
  parameter logic [6:0] RESET_GAP = 7'h08  // equals the reset floor code
) (
  input  wire logic       sys_clk_in,      // system clock
  input  wire logic       rst_in,          // synchronous reset, high
  input  wire logic       freeze_in,       // 1 holds the present gap
  input  wire logic [6:0] floor_in,        // least gap, 2 ns units
  input  wire logic [6:0] adapt_in,        // proposal from the optimiser
  input  wire logic       adapt_valid_in,  // proposal strobe
  output logic      [6:0] gap_out          // gap in use, 2 ns units
);

  logic [6:0] gap_r;  // gap in use

  // larger of two codes, used for both clamp paths
  function automatic logic [6:0] dlsc_max7(input logic [6:0] a, input logic [6:0] b);
    dlsc_max7 = (a > b) ? a : b;
  endfunction : dlsc_max7

  // adaptive tracking; freezing simply stops updates, so the last
  // adaptive value becomes the frozen one without any copy
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      gap_r <= RESET_GAP;
    end else if (!freeze_in) begin
      if (adapt_valid_in) begin
        gap_r <= dlsc_max7(adapt_in, floor_in);
      end else begin
        // a raised floor lifts the gap at once
        gap_r <= dlsc_max7(gap_r, floor_in);
      end
    end
    // frozen: hold
  end

  assign gap_out = gap_r;

endmodule : dlsc_gap_track

// [hw/dlsc_params.svh]
// constants for the dead-time, loop-response and rail-order configuration block
`ifndef DLSC_PARAMS_SVH
`define DLSC_PARAMS_SVH

// management-bus command codes
`define DLSC_CMD_GAP          8'hde
`define DLSC_CMD_LOOP         8'hdf
`define DLSC_CMD_ORDER        8'he0

// reset values
`define DLSC_GAP_RESET        16'h0808
`define DLSC_LOOP_RESET       32'h015a0100
`define DLSC_ORDER_RESET      16'h0000

// writable-bit masks, unused positions are zero
`define DLSC_GAP_MASK         16'hffff
`define DLSC_LOOP_MASK        32'h01ffffff
`define DLSC_ORDER_MASK       16'h9f9f

// field positions
`define DLSC_GAP_HL_FRZ_BIT   15
`define DLSC_GAP_HL_MIN_LSB   8
`define DLSC_GAP_LH_FRZ_BIT   7
`define DLSC_GAP_LH_MIN_LSB   0
`define DLSC_LOOP_EN_BIT      24
`define DLSC_LOOP_RES_LSB     16
`define DLSC_LOOP_GAIN_LSB    0
`define DLSC_ORDER_PRE_EN_BIT 15
`define DLSC_ORDER_PRE_ID_LSB 8
`define DLSC_ORDER_SEQ_EN_BIT 7
`define DLSC_ORDER_SEQ_ID_LSB 0

// dead-time floor resolution in ns per count
`define DLSC_GAP_STEP_NS      2
// cycles after reset release before the strap is captured
`define DLSC_STRAP_WAIT       2'h2
// derived residual baseline and gain baseline
`define DLSC_DERIVE_RES       8'h5a
`define DLSC_DERIVE_GAIN      16'h0100

`endif

// [hw/dlsc_pkg.sv]
// types for the dead-time, loop-response and rail-order configuration block
package dlsc_pkg;

  // dead-time setup word, layout matches the register bits
  typedef struct packed {
    logic       hl_frz;   // 1 freezes high-to-low gap
    logic [6:0] hl_min;   // high-to-low floor, 2 ns units
    logic       lh_frz;   // 1 freezes low-to-high gap
    logic [6:0] lh_min;   // low-to-high floor, 2 ns units
  } dlsc_gap_cfg_t;

  // loop-response setup word
  typedef struct packed {
    logic [6:0]  unused;  // always zero
    logic        en;      // 1 enables loop-response control
    logic [7:0]  res;     // residual
    logic [15:0] gain;    // gain
  } dlsc_loop_cfg_t;

  // rail-order links word
  typedef struct packed {
    logic       pre_en;   // wait for predecessor power-good
    logic [1:0] pad_hi;   // always zero
    logic [4:0] pre_id;   // predecessor bus identifier
    logic       seq_en;   // follow successor power-down
    logic [1:0] pad_lo;   // always zero
    logic [4:0] seq_id;   // successor bus identifier
  } dlsc_order_cfg_t;

  // event kinds seen on the inter-chip bus
  typedef enum logic {
    DLSC_EVT_POWER_GOOD = 1'b0,
    DLSC_EVT_POWER_DOWN = 1'b1
  } dlsc_evt_kind_t;

  // rail sequencing states
  typedef enum logic [1:0] {
    DLSC_RAIL_OFF   = 2'b00,
    DLSC_RAIL_ON    = 2'b01,
    DLSC_RAIL_DELAY = 2'b10
  } dlsc_rail_state_t;

endpackage : dlsc_pkg

// [test/dlsc_config_props.sv]
// port-level assertion checker for the configuration block
`timescale 1ns/10ps
module dlsc_config_props (
  input wire logic        sys_clk_in,     // system clock
  input wire logic        rst_in,         // synchronous reset, high
  input wire logic        cmd_valid_in,   // command strobe
  input wire logic        cmd_write_in,   // 1 write
  input wire logic [7:0]  cmd_code_in,    // command code
  input wire logic [31:0] cmd_wdata_in,   // write data
  input wire logic        cmd_ack_out,    // answer strobe
  input wire logic        cmd_err_out,    // unknown code
  input wire logic [31:0] cmd_rdata_out,  // read data
  input wire logic [6:0]  hl_gap_out,     // high-to-low gap
  input wire logic        hl_frozen_out,  // high-to-low frozen
  input wire logic        lh_frozen_out,  // low-to-high frozen
  input wire logic        loop_enable_out,
  input wire logic [7:0]  loop_residual_out,
  input wire logic [15:0] loop_gain_out,
  input wire logic        on_req_in,      // on/off condition
  input wire logic        rail_on_out,    // output stage on
  input wire logic [1:0]  rail_state_out  // sequencing state
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // write and read qualifiers
  logic wr, rd;
  assign wr = cmd_valid_in & cmd_write_in;
  assign rd = cmd_valid_in & ~cmd_write_in;
  AST_ACK: assert property (cmd_valid_in |=> cmd_ack_out)
    else $error("command not answered");
  AST_ERR: assert property (cmd_valid_in && !(cmd_code_in inside {8'hde, 8'hdf, 8'he0})
    |=> cmd_err_out) else $error("unknown code not flagged");
  AST_HL_FRZ: assert property (wr && cmd_code_in == 8'hde
    |=> hl_frozen_out == $past(cmd_wdata_in[15])) else $error("hl mode wrong");
  AST_LH_FRZ: assert property (wr && cmd_code_in == 8'hde
    |=> lh_frozen_out == $past(cmd_wdata_in[7])) else $error("lh mode wrong");
  AST_LOOP: assert property (wr && cmd_code_in == 8'hdf |=>
    {loop_enable_out, loop_residual_out, loop_gain_out} == $past(cmd_wdata_in[24:0]))
    else $error("loop fields wrong");
  AST_HOLD: assert property (hl_frozen_out |=> $stable(hl_gap_out))
    else $error("frozen gap moved");
  AST_ORD_RD: assert property (rd && cmd_code_in == 8'he0 |=> cmd_rdata_out[31:16] == 16'h0
    && cmd_rdata_out[14:13] == 2'h0 && cmd_rdata_out[6:5] == 2'h0) else $error("unused set");
  AST_OFF: assert property (rail_state_out == 2'h0 && !on_req_in |=> !rail_on_out)
    else $error("rail on without request");
  AST_DLY: assert property (rail_state_out == 2'h1 && !on_req_in
    |=> rail_state_out == 2'h2 && rail_on_out) else $error("no delayed turn-off");
  // main scenarios reached
  COV_GAP: cover property (wr && cmd_code_in == 8'hde);
  COV_ON: cover property ($rose(rail_on_out));
  COV_DLY: cover property (rail_state_out == 2'h2);
endmodule : dlsc_config_props

bind dlsc_config dlsc_config_props u_dlsc_config_props (.sys_clk_in, .rst_in, .cmd_valid_in,
  .cmd_write_in, .cmd_code_in, .cmd_wdata_in, .cmd_ack_out, .cmd_err_out, .cmd_rdata_out,
  .hl_gap_out, .hl_frozen_out, .lh_frozen_out, .loop_enable_out, .loop_residual_out,
  .loop_gain_out, .on_req_in, .rail_on_out, .rail_state_out);

// [test/dlsc_config_tb.sv]
// self-checking bench for the configuration block
`timescale 1ns/10ps
module dlsc_config_tb;
  localparam int DLY = 3;  // short turn-off delay keeps the run brief
  logic sys_clk_in = 0, rst_in = 1, cmd_valid_in = 0, cmd_write_in = 0, derive_in = 0;
  logic hl_adapt_valid_in = 0, lh_adapt_valid_in = 0, on_req_in = 0, e;
  logic [6:0] hl_adapt_in = 0, lh_adapt_in = 0, hl_gap_out, lh_gap_out;
  logic [7:0] cmd_code_in = 0, loop_residual_out;
  logic [31:0] cmd_wdata_in = 0, cmd_rdata_out, r, d;
  logic [11:0] vin_in = 0, vout_in = 0;
  logic [15:0] strap_order_in = 16'h8303, off_delay_in = 16'(DLY), loop_gain_out;
  logic cmd_ack_out, cmd_err_out, hl_frozen_out, lh_frozen_out, loop_enable_out, rail_on_out;
  logic evt_valid_in, evt_kind_in;
  logic [4:0] evt_id_in;
  logic [1:0] rail_state_out;
  int num_errors = 0, checks_done = 0, seed = 32'h52fd, n, fl, mg;
  logic [7:0] cd[4] = '{8'hde, 8'hdf, 8'he0, 8'h55};  // last code is unmapped
  logic [31:0] msk[4] = '{32'hffff, 32'h01ffffff, 32'h9f9f, 32'h0};
  logic [31:0] mdl[4] = '{32'h0808, 32'h015a0100, 32'h0, 32'h0};  // register model
  always #25 sys_clk_in = ~sys_clk_in;
  dlsc_config u_dlsc_config (.sys_clk_in, .rst_in, .cmd_valid_in, .cmd_write_in, .cmd_code_in,
    .cmd_wdata_in, .cmd_ack_out, .cmd_err_out, .cmd_rdata_out, .hl_adapt_in, .hl_adapt_valid_in,
    .lh_adapt_in, .lh_adapt_valid_in, .hl_gap_out, .lh_gap_out, .hl_frozen_out, .lh_frozen_out,
    .vin_in, .vout_in, .derive_in, .loop_enable_out, .loop_residual_out, .loop_gain_out,
    .strap_order_in, .on_req_in, .evt_valid_in, .evt_kind_in, .evt_id_in, .off_delay_in,
    .rail_on_out, .rail_state_out);
  dlsc_peer_rail u_dlsc_peer_rail (.sys_clk_in, .evt_valid_out(evt_valid_in),
    .evt_kind_out(evt_kind_in), .evt_id_out(evt_id_in));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask : cyc
  // one command; reads after the answer edge see the answer cycle
  task automatic cmd(input logic w, input logic [7:0] c, input logic [31:0] wd);
    {cmd_valid_in, cmd_write_in, cmd_code_in, cmd_wdata_in} <= {1'b1, w, c, wd};
    cyc(1);
    cmd_valid_in <= 1'b0;
    cyc(1);
    r = cmd_rdata_out;
    e = cmd_err_out;
    chk(32'(cmd_ack_out), 32'h1);
  endtask : cmd
  // optimiser proposal on both transitions; gap model follows floor and freeze
  task automatic gap(input int a, input logic frz);
    {hl_adapt_in, lh_adapt_in, hl_adapt_valid_in, lh_adapt_valid_in} <= {7'(a), 7'(a), 2'b11};
    cyc(1);
    {hl_adapt_valid_in, lh_adapt_valid_in} <= 2'b00;
    cyc(1);
    if (!frz) mg = (a > fl) ? a : fl;
    chk(32'(hl_gap_out), mg);
    chk(32'(lh_gap_out), mg);
  endtask : gap
  // count cycles spent in the delayed turn-off state
  task automatic dly();
    n = 0;
    repeat (DLY + 6) begin
      cyc(1);
      if (rail_state_out === 2'h2) n++;
    end
    chk(n, DLY + 1);
  endtask : dly
  task automatic close_out();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // watchdog: the run needs about a hundred and ten cycles
  initial begin
    cyc(3000);
    num_errors++;
    close_out();
  end
  initial begin
    cyc(10);
    rst_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      cmd(1'b0, cd[i], 32'h0);
      chk(r, mdl[i]);
    end
    chk(32'({hl_gap_out, lh_gap_out}), 32'h0408);
    // strap asks for a predecessor until the register is written
    on_req_in <= 1'b1;
    cyc(5);
    chk(32'(rail_on_out), 32'h0);
    u_dlsc_peer_rail.send(1'b0, 5'd3);
    cyc(1);
    chk(32'(rail_on_out), 32'h1);
    on_req_in <= 1'b0;
    dly();
    cmd(1'b1, 8'he0, 32'h0);
    on_req_in <= 1'b1;
    cyc(2);
    chk(32'(rail_on_out), 32'h1);
    on_req_in <= 1'b0;
    dly();
    cmd(1'b1, 8'he0, 32'h8385);
    on_req_in <= 1'b1;
    u_dlsc_peer_rail.send(1'b0, 5'd4);
    cyc(3);
    chk(32'(rail_on_out), 32'h0);
    u_dlsc_peer_rail.send(1'b0, 5'd3);
    cyc(1);
    chk(32'(rail_on_out), 32'h1);
    u_dlsc_peer_rail.send(1'b1, 5'd4);
    cyc(2);
    chk(32'(rail_state_out), 32'h1);
    u_dlsc_peer_rail.send(1'b1, 5'd5);
    dly();
    on_req_in <= 1'b0;
    cyc(DLY + 4);
    // random words, then read back through the mask; last code is unmapped
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      cmd(1'b1, cd[i], d);
      mdl[i] = d & msk[i];
      chk(32'(e), 32'(i == 3));
      cmd(1'b0, cd[i], 32'h0);
      chk(r, mdl[i]);
    end
    chk(32'({hl_frozen_out, lh_frozen_out}), 32'({mdl[0][15], mdl[0][7]}));
    chk(32'({loop_enable_out, loop_residual_out, loop_gain_out}), mdl[1] & msk[1]);
    // floors clamp, freeze holds the last gap
    fl = 10;
    cmd(1'b1, 8'hde, 32'h0a0a);
    gap(3, 1'b0);
    gap(40, 1'b0);
    cmd(1'b1, 8'hde, 32'h8a8a);
    gap(90, 1'b1);
    cmd(1'b1, 8'hde, 32'h0a0a);
    gap(5, 1'b0);
    // defaults derived from the measured voltages
    {vin_in, vout_in, derive_in} <= {12'd400, 12'd100, 1'b1};
    cyc(1);
    derive_in <= 1'b0;
    cyc(1);
    chk(32'(loop_gain_out), 32'h100 + ((400 - 100) >> 2));
    chk(32'(loop_residual_out), 32'h5a);
    close_out();
  end
endmodule : dlsc_config_tb

// [test/dlsc_peer_rail.sv]
// peer rail model: sends power-good and power-down events
`timescale 1ns/10ps
module dlsc_peer_rail (
  input  wire logic       sys_clk_in,     // shared clock
  output logic            evt_valid_out,  // one-cycle event strobe
  output logic            evt_kind_out,   // 0 power-good, 1 power-down
  output logic      [4:0] evt_id_out      // sender identifier
);
  initial begin
    evt_valid_out = 1'b0;
    evt_kind_out  = 1'b0;
    evt_id_out    = 5'h0;
  end
  // one event, called just after a rising edge; afterwards the idle
  // fields show the inverse rather than the last event
  task automatic send(input logic k, input logic [4:0] id);
    evt_valid_out <= 1'b1;
    evt_kind_out  <= k;
    evt_id_out    <= id;
    @(posedge sys_clk_in);
    evt_valid_out <= 1'b0;
    evt_kind_out  <= ~k;
    evt_id_out    <= ~id;
  endtask : send
endmodule : dlsc_peer_rail
